// *** hdl/wcfe_consts.vh ***
// Constants for the wakeup control and wakeup filter enable register bank.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef WCFE_CONSTS_VH
`define WCFE_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, low 16 address bits)
// ----------------------------------------------------------------------
`define WCFE_OFS_WAKEUP_CONTROL       16'h5800
`define WCFE_OFS_WAKEUP_FILTER_ENABLE 16'h5808
`define WCFE_OFS_WIDTH                16

// ----------------------------------------------------------------------
// Wakeup control field positions
// ----------------------------------------------------------------------
`define WCFE_CTL_ADV_WAKE_ENABLE      0
`define WCFE_CTL_WAKE_EVENT_ENABLE    1
`define WCFE_CTL_WAKE_EVENT_STATUS    2
`define WCFE_CTL_ADV_WAKE_ASSERT      3
`define WCFE_CTL_DYN_POWERDOWN        28
`define WCFE_CTL_HALF_AT_GIG          29
`define WCFE_CTL_QUARTER_BELOW_GIG    30
`define WCFE_CTL_SMART_POWERDOWN      31

// ----------------------------------------------------------------------
// Wakeup filter enable field positions
// ----------------------------------------------------------------------
`define WCFE_FILT_LINK_CHANGE         0
`define WCFE_FILT_WAKE_PATTERN        1
`define WCFE_FILT_EXACT_MATCH         2
`define WCFE_FILT_HASH_GROUP          3
`define WCFE_FILT_BROADCAST           4
`define WCFE_FILT_ARP_REQUEST         5
`define WCFE_FILT_DIRECTED_IPV4       6
`define WCFE_FILT_DIRECTED_IPV6       7
`define WCFE_FILT_IGNORE_MGMT         15
`define WCFE_FILT_FLEX_LSB            16
`define WCFE_FILT_FLEX_MSB            19
`define WCFE_NUM_FIXED_FILTERS        8
`define WCFE_NUM_FLEX_FILTERS         4

// ----------------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------------
`define WCFE_CTL_RW_MASK              32'hF000000B
`define WCFE_FILT_RW_MASK             32'h000F80FF
`define WCFE_CTL_RESET                32'h00000000
`define WCFE_FILT_RESET               32'h00000000

// ----------------------------------------------------------------------
// MAC clock divide codes
// ----------------------------------------------------------------------
`define WCFE_MAC_DIV_FULL             2'h0
`define WCFE_MAC_DIV_HALF             2'h1
`define WCFE_MAC_DIV_QUARTER          2'h2

// ----------------------------------------------------------------------
// AHB-Lite encodings
// ----------------------------------------------------------------------
`define WCFE_HTRANS_NONSEQ_BIT        1
`define WCFE_HSIZE_WORD               3'h2
`define WCFE_HRESP_OKAY               1'h0

`endif

// *** hdl/wcfe_regs.v ***
// Wakeup control and wakeup filter enable registers behind an AHB-Lite slave.
// Assumes one clock hclk, filter-match strobes from logic on hclk, and
// power-good, standby and host reset levels arriving from pins.

`include "wcfe_consts.vh"

module wcfe_regs #(
  parameter NUM_FLEX = `WCFE_NUM_FLEX_FILTERS   // Flexible pattern filters
) (
  hclk,
  hresetn,
  clk_en,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hrdata,
  hresp,
  main_power_good,
  standby_present,
  host_reset_n,
  eeprom_adv_wake_assert_event,
  cfg_enable_write,
  cfg_enable_data,
  cfg_status_clear,
  link_change_hit,
  wake_pattern_hit,
  exact_match_hit,
  hash_group_hit,
  broadcast_hit,
  arp_request_hit,
  ipv4_directed_hit,
  ipv6_directed_hit,
  flex_hit,
  pkt_is_mgmt,
  link_is_gig,
  pci_is_33mhz,
  mac_freq_sel,
  adv_wake_enable,
  wake_event_enable,
  wake_event_status,
  dyn_powerdown,
  smart_powerdown,
  mac_clk_div,
  filter_enables,
  wake_event_pin_n,
  wake_event_pin_oe_n
);

  // --------------------------------------------------------------------
  // Ports
  // --------------------------------------------------------------------
  input  wire                hclk;                       // Bus clock, 250 MHz
  input  wire                hresetn;                    // Async reset, active low
  input  wire                clk_en;                     // Freezes all state when low
  input  wire                hsel;                       // Slave select
  input  wire [31:0]         haddr;                      // Byte address
  input  wire [1:0]          htrans;                     // Transfer type
  input  wire                hwrite;                     // Write when high
  input  wire [2:0]          hsize;                      // Transfer size
  input  wire [31:0]         hwdata;                     // Write data
  input  wire                hready;                     // Bus ready
  output wire                hreadyout;                  // Slave ready
  output wire [31:0]         hrdata;                     // Read data
  output wire                hresp;                      // Always OKAY
  input  wire                main_power_good;            // Pin, main supply good
  input  wire                standby_present;            // Pin, standby supply present
  input  wire                host_reset_n;               // Pin, host reset active low
  input  wire                eeprom_adv_wake_assert_event; // EEPROM default of bit 3
  input  wire                cfg_enable_write;           // Config space writes enable
  input  wire                cfg_enable_data;            // New config enable value
  input  wire                cfg_status_clear;           // Config space write-one-clear
  input  wire                link_change_hit;            // Link status changed
  input  wire                wake_pattern_hit;           // Wake pattern packet seen
  input  wire                exact_match_hit;            // Matched a receive address entry
  input  wire                hash_group_hit;             // Hash table bit was one
  input  wire                broadcast_hit;              // Broadcast packet
  input  wire                arp_request_hit;            // ARP request packet
  input  wire                ipv4_directed_hit;          // Directed IPv4 packet
  input  wire                ipv6_directed_hit;          // Directed IPv6 packet
  input  wire [NUM_FLEX-1:0] flex_hit;                   // Flexible filter matches
  input  wire                pkt_is_mgmt;                // Hit came from a management packet
  input  wire                link_is_gig;                // Link runs at 1000 Mb/s
  input  wire                pci_is_33mhz;               // PCI bus at 33 MHz
  input  wire [1:0]          mac_freq_sel;               // Separate MAC frequency select
  output wire                adv_wake_enable;            // Control bit 0
  output wire                wake_event_enable;          // Control bit 1
  output wire                wake_event_status;          // Control bit 2
  output wire                dyn_powerdown;              // Control bit 28
  output wire                smart_powerdown;            // Control bit 31
  output wire [1:0]          mac_clk_div;                // Effective MAC clock divide
  output wire [31:0]         filter_enables;             // Filter enable register
  output wire                wake_event_pin_n;           // Open-drain pin level, low
  output wire                wake_event_pin_oe_n;        // Low while pin is driven

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  reg  [31:0] ctrl_ff;            // Wakeup control storage
  reg  [31:0] nxt_ctrl;
  reg  [31:0] filt_ff;            // Wakeup filter enable storage
  reg  [31:0] nxt_filt;
  reg  [1:0]  mac_div_ff;         // Registered MAC clock divide
  reg  [1:0]  nxt_mac_div;
  reg         pin_drive_ff;       // Registered pin drive
  reg  [31:0] hrdata_ff;          // Read data register
  reg  [31:0] nxt_hrdata;

  // Synchronisers: first stage feeds only the second stage
  reg  [1:0]  pg_sync_ff;         // Power good
  reg  [1:0]  sb_sync_ff;         // Standby present
  reg  [1:0]  rst_sync_ff;        // Host reset
  reg         rst_prev_ff;        // Last synced host reset, for edge detect

  // Bus pipeline
  localparam [2:0] ST_IDLE  = 3'h1;  // No transfer pending
  localparam [2:0] ST_WRITE = 3'h2;  // Write data phase
  localparam [2:0] ST_READ  = 3'h4;  // Read data phase, one wait state
  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [`WCFE_OFS_WIDTH-1:0] addr_ff;   // Captured address
  reg         rd_done_ff;         // Read data now valid
  reg         nxt_rd_done;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // Two flops per pin, frozen with the rest of the block
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pg_sync_ff  <= 2'h0;
      sb_sync_ff  <= 2'h0;
      rst_sync_ff <= 2'h3;  // Idle high, so no false release edge
      rst_prev_ff <= 1'h1;
    end else if (clk_en) begin
      pg_sync_ff  <= {pg_sync_ff[0], main_power_good};
      sb_sync_ff  <= {sb_sync_ff[0], standby_present};
      rst_sync_ff <= {rst_sync_ff[0], host_reset_n};
      rst_prev_ff <= rst_sync_ff[1];
    end
  end

  wire pg_ok      = pg_sync_ff[1];                  // Main power good, synced
  wire sb_ok      = sb_sync_ff[1];                  // Standby present, synced
  wire rst_rise   = rst_sync_ff[1] & ~rst_prev_ff;  // Host reset released
  // Power loss clears continuously; reset release clears only without standby
  wire bank_clear = ~pg_ok | (rst_rise & ~sb_ok);

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire        take     = hsel & hready & htrans[`WCFE_HTRANS_NONSEQ_BIT];
  wire        is_ctrl  = (addr_ff == `WCFE_OFS_WAKEUP_CONTROL);
  wire        is_filt  = (addr_ff == `WCFE_OFS_WAKEUP_FILTER_ENABLE);
  wire        wr_ctrl  = (state_ff == ST_WRITE) & is_ctrl;
  wire        wr_filt  = (state_ff == ST_WRITE) & is_filt;

  // Reads hold one wait state so a write just before is always seen
  assign hreadyout = ~((state_ff == ST_READ) & ~rd_done_ff);
  assign hresp     = `WCFE_HRESP_OKAY;
  assign hrdata    = hrdata_ff;

  // Bus state machine
  always @* begin
    nxt_state   = state_ff;
    nxt_rd_done = 1'h0;
    case (state_ff)
      ST_IDLE, ST_WRITE: begin
        // New address phase may overlap a write data phase
        if (take) begin
          nxt_state = hwrite ? ST_WRITE : ST_READ;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      ST_READ: begin
        if (!rd_done_ff) begin
          // Wait cycle: data loaded at this edge
          nxt_rd_done = 1'h1;
        end else if (take) begin
          nxt_state = hwrite ? ST_WRITE : ST_READ;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Read data selection, unmapped addresses read as zero
  always @* begin
    nxt_hrdata = hrdata_ff;
    if ((state_ff == ST_READ) && !rd_done_ff) begin
      if (is_ctrl) begin
        nxt_hrdata = ctrl_ff;
      end else if (is_filt) begin
        nxt_hrdata = filt_ff;
      end else begin
        nxt_hrdata = 32'h00000000;
      end
    end
  end

  // --------------------------------------------------------------------
  // Wakeup match evaluation
  // --------------------------------------------------------------------
  // Management packets may be excluded; a link change is no packet
  wire pkt_ok = ~(filt_ff[`WCFE_FILT_IGNORE_MGMT] & pkt_is_mgmt);

  wire [`WCFE_NUM_FIXED_FILTERS-1:0] fixed_hit = {
    ipv6_directed_hit & pkt_ok,
    ipv4_directed_hit & pkt_ok,
    arp_request_hit   & pkt_ok,
    broadcast_hit     & pkt_ok,
    hash_group_hit    & pkt_ok,
    exact_match_hit   & pkt_ok,
    wake_pattern_hit  & pkt_ok,
    link_change_hit
  };

  // One gate per filter, fixed then flexible
  wire [`WCFE_NUM_FIXED_FILTERS-1:0] fixed_wake;
  wire [NUM_FLEX-1:0]                flex_wake;
  genvar gi;
  generate
    for (gi = 0; gi < `WCFE_NUM_FIXED_FILTERS; gi = gi + 1) begin : g_fixed
      assign fixed_wake[gi] = fixed_hit[gi] & filt_ff[gi];
    end
    for (gi = 0; gi < NUM_FLEX; gi = gi + 1) begin : g_flex
      assign flex_wake[gi] = flex_hit[gi] & pkt_ok &
                             filt_ff[`WCFE_FILT_FLEX_LSB + gi];
    end
  endgenerate

  // Advanced wakeup path on a wake pattern packet
  wire adv_wake = ctrl_ff[`WCFE_CTL_ADV_WAKE_ENABLE] &
                  ctrl_ff[`WCFE_CTL_ADV_WAKE_ASSERT] &
                  wake_pattern_hit & pkt_ok;
  wire wake_set = adv_wake | (|fixed_wake) | (|flex_wake);

  // --------------------------------------------------------------------
  // Control register next value
  // --------------------------------------------------------------------
  // Status set wins over a bus or config-space clear in the same cycle; a bank clear wins over the set
  always @* begin
    nxt_ctrl = ctrl_ff;
    if (bank_clear) begin
      // Bit 3 default is the EEPROM image, all else zero
      nxt_ctrl = `WCFE_CTL_RESET;
      nxt_ctrl[`WCFE_CTL_ADV_WAKE_ASSERT] = eeprom_adv_wake_assert_event;
    end else begin
      if (wr_ctrl) begin
        // Plain read/write fields, reserved stay zero
        nxt_ctrl = (ctrl_ff & ~`WCFE_CTL_RW_MASK) | (hwdata & `WCFE_CTL_RW_MASK);
        nxt_ctrl[`WCFE_CTL_WAKE_EVENT_STATUS] = ctrl_ff[`WCFE_CTL_WAKE_EVENT_STATUS];
        if (hwdata[`WCFE_CTL_WAKE_EVENT_STATUS]) begin
          nxt_ctrl[`WCFE_CTL_WAKE_EVENT_STATUS] = 1'h0;
        end
      end
      // Config space path to the same enable bit
      if (cfg_enable_write) begin
        nxt_ctrl[`WCFE_CTL_WAKE_EVENT_ENABLE] = cfg_enable_data;
      end
      if (cfg_status_clear) begin
        nxt_ctrl[`WCFE_CTL_WAKE_EVENT_STATUS] = 1'h0;
      end
      if (wake_set) begin
        nxt_ctrl[`WCFE_CTL_WAKE_EVENT_STATUS] = 1'h1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Filter enable register next value
  // --------------------------------------------------------------------
  // Reserved 14:8 are not stored, so a stray write reads back zero
  always @* begin
    nxt_filt = filt_ff;
    if (bank_clear) begin
      nxt_filt = `WCFE_FILT_RESET;
    end else if (wr_filt) begin
      nxt_filt = hwdata & `WCFE_FILT_RW_MASK;
    end
  end

  // --------------------------------------------------------------------
  // MAC clock rate selection
  // --------------------------------------------------------------------
  // Divide is registered so the clock generator sees a glitch-free code
  always @* begin
    nxt_mac_div = `WCFE_MAC_DIV_FULL;
    if (!ctrl_ff[`WCFE_CTL_HALF_AT_GIG] && !ctrl_ff[`WCFE_CTL_QUARTER_BELOW_GIG]) begin
      nxt_mac_div = mac_freq_sel;
    end else if (link_is_gig) begin
      if (ctrl_ff[`WCFE_CTL_HALF_AT_GIG] && pci_is_33mhz) begin
        nxt_mac_div = `WCFE_MAC_DIV_HALF;
      end
    end else if (ctrl_ff[`WCFE_CTL_QUARTER_BELOW_GIG]) begin
      nxt_mac_div = `WCFE_MAC_DIV_QUARTER;
    end
  end

  // --------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff     <= ST_IDLE;
      addr_ff      <= {`WCFE_OFS_WIDTH{1'b0}};
      rd_done_ff   <= 1'h0;
      hrdata_ff    <= 32'h00000000;
      ctrl_ff      <= `WCFE_CTL_RESET;
      filt_ff      <= `WCFE_FILT_RESET;
      mac_div_ff   <= `WCFE_MAC_DIV_FULL;
      pin_drive_ff <= 1'h0;
    end else if (clk_en) begin
      state_ff     <= nxt_state;
      rd_done_ff   <= nxt_rd_done;
      hrdata_ff    <= nxt_hrdata;
      ctrl_ff      <= nxt_ctrl;
      filt_ff      <= nxt_filt;
      mac_div_ff   <= nxt_mac_div;
      // Pin follows next status and enable, so it changes on the same edge as them
      pin_drive_ff <= nxt_ctrl[`WCFE_CTL_WAKE_EVENT_STATUS] &
                      nxt_ctrl[`WCFE_CTL_WAKE_EVENT_ENABLE];
      // Only whole words are mapped; a narrower access decodes to nothing
      if (take && hreadyout) begin
        addr_ff <= (hsize == `WCFE_HSIZE_WORD) ? haddr[`WCFE_OFS_WIDTH-1:0]
                                               : {`WCFE_OFS_WIDTH{1'b1}};
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign adv_wake_enable     = ctrl_ff[`WCFE_CTL_ADV_WAKE_ENABLE];
  assign wake_event_enable   = ctrl_ff[`WCFE_CTL_WAKE_EVENT_ENABLE];
  assign wake_event_status   = ctrl_ff[`WCFE_CTL_WAKE_EVENT_STATUS];
  assign dyn_powerdown       = ctrl_ff[`WCFE_CTL_DYN_POWERDOWN];
  assign smart_powerdown     = ctrl_ff[`WCFE_CTL_SMART_POWERDOWN];
  assign mac_clk_div         = mac_div_ff;
  assign filter_enables      = filt_ff;
  // Open drain: drives low only, released otherwise
  assign wake_event_pin_n    = 1'h0;
  assign wake_event_pin_oe_n = ~pin_drive_ff;

endmodule

// *** verif/wcfe_regs_chk.sv ***
// Port checker for the wakeup register bank.
// Assumes it is bound onto wcfe_regs with clk_en held high.
`include "wcfe_consts.vh"
module wcfe_regs_chk #(
  parameter NUM_FLEX = 4
) (
  input wire logic                hclk, hresetn, hsel, hwrite, hready, hreadyout,
  input wire logic [31:0]         haddr, hwdata, filter_enables,
  input wire logic [1:0]          htrans,
  input wire logic [2:0]          hsize,
  input wire logic                main_power_good, cfg_enable_write, cfg_enable_data,
  input wire logic                link_change_hit, wake_pattern_hit, exact_match_hit,
  input wire logic                hash_group_hit, broadcast_hit, arp_request_hit,
  input wire logic                ipv4_directed_hit, ipv6_directed_hit, pkt_is_mgmt,
  input wire logic [NUM_FLEX-1:0] flex_hit,
  input wire logic                adv_wake_enable, wake_event_enable, wake_event_status,
  input wire logic                dyn_powerdown, smart_powerdown,
  input wire logic                wake_event_pin_n, wake_event_pin_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Decode helpers
  // ----
  logic        taken, wr_ctl, wr_flt, any_hit;
  logic [31:0] hw_q;  // Write data seen one cycle late, at the landing edge
  assign taken   = hsel && hready && htrans[1] && hreadyout && hsize == `WCFE_HSIZE_WORD;
  assign wr_ctl  = taken && hwrite && haddr[15:0] == `WCFE_OFS_WAKEUP_CONTROL;
  assign wr_flt  = taken && hwrite && haddr[15:0] == `WCFE_OFS_WAKEUP_FILTER_ENABLE;
  assign any_hit = link_change_hit || wake_pattern_hit || exact_match_hit || hash_group_hit
                 || broadcast_hit || arp_request_hit || ipv4_directed_hit
                 || ipv6_directed_hit || (|flex_hit);
  // Data phase value, kept so it can be compared after the write lands
  always_ff @(posedge hclk) begin
    hw_q <= hwdata;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----
  // Assertions
  // ----
  a_bank_clear: assert property (!main_power_good [*3] |=> filter_enables == 32'h0
    && !dyn_powerdown && !smart_powerdown && !adv_wake_enable) else $error("bank not cleared");
  a_ctrl_write: assert property (wr_ctl && main_power_good ##1 main_power_good |=>
    {adv_wake_enable, dyn_powerdown, smart_powerdown} == {hw_q[0], hw_q[28], hw_q[31]})
    else $error("control write not applied");
  a_filt_write: assert property (wr_flt && main_power_good ##1 main_power_good |=>
    filter_enables == (hw_q & `WCFE_FILT_RW_MASK)) else $error("filter write not applied");
  a_pin_follows: assert property (wake_event_pin_n == 1'b0 &&
    wake_event_pin_oe_n == !(wake_event_status && wake_event_enable)) else $error("pin wrong");
  a_link_wake: assert property (link_change_hit && filter_enables[0] && main_power_good
    |=> wake_event_status) else $error("link change did not wake");
  a_ignore_mgmt: assert property (!wake_event_status && filter_enables[15] && pkt_is_mgmt
    && !link_change_hit && !wake_pattern_hit |=> !wake_event_status)
    else $error("management packet woke");
  a_status_w1c: assert property (wr_ctl ##1 (hwdata[2] && !any_hit)
    |=> !wake_event_status) else $error("status not cleared");
  a_cfg_alias: assert property (cfg_enable_write |=>
    wake_event_enable == $past(cfg_enable_data)) else $error("config enable not mirrored");
  c_pin_low: cover property (!wake_event_pin_oe_n);
  c_link: cover property (link_change_hit && filter_enables[0]);
  c_power_drop: cover property (!main_power_good [*3]);
endmodule

// *** verif/wcfe_pm_host.sv ***
// Host power management model: config-space enable and status strobes.
// Assumes shared hclk; its tasks are entered right after a rising edge.
module wcfe_pm_host (
  input  wire logic hclk,
  input  wire logic wake_event_pin_n,
  input  wire logic wake_event_pin_oe_n,
  output logic      cfg_enable_write,
  output logic      cfg_enable_data,
  output logic      cfg_status_clear,
  output wire logic wake_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // Board pull-up: the line is high whenever nobody pulls it low
  assign wake_line = wake_event_pin_oe_n ? 1'h1 : wake_event_pin_n;
  initial begin
    cfg_enable_write = 1'h0;
    cfg_enable_data  = 1'h0;
    cfg_status_clear = 1'h0;
  end
  // One-cycle config write of the enable bit; data not held past it
  task automatic set_enable(input logic v);
    cfg_enable_data  <= v;
    cfg_enable_write <= 1'h1;
    @(posedge hclk);
    cfg_enable_write <= 1'h0;
    cfg_enable_data  <= ~v;
    @(posedge hclk);
  endtask
  // Write-one-clear of the shared status from config space
  task automatic clear_status;
    cfg_status_clear <= 1'h1;
    @(posedge hclk);
    cfg_status_clear <= 1'h0;
    @(posedge hclk);
  endtask
endmodule

// *** verif/wakeup_control_filter_enable_tb_top.sv ***
// Testbench for the wakeup register bank over AHB-Lite.
// Assumes hdl/wcfe_consts.vh on the include path; clk_en and hsize held.
`include "wcfe_consts.vh"
module wakeup_control_filter_enable_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] CTL = 32'(`WCFE_OFS_WAKEUP_CONTROL);
  localparam logic [31:0] FLT = 32'(`WCFE_OFS_WAKEUP_FILTER_ENABLE);
  logic hclk = 1'h0, hresetn = 1'h0, clk_en = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic main_power_good = 1'h1, standby_present = 1'h1, host_reset_n = 1'h1;
  logic eeprom_adv_wake_assert_event = 1'h1, pkt_is_mgmt = 1'h0;
  logic link_is_gig = 1'h0, pci_is_33mhz = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, filter_enables, rd;
  logic [1:0]  htrans = 2'h0, mac_freq_sel = 2'h0, mac_clk_div;
  logic [2:0]  hsize = `WCFE_HSIZE_WORD;
  logic [11:0] hits = 12'h0;  // Fixed filter pulses low, flexible ones high
  logic hreadyout, hresp, cfg_enable_write, cfg_enable_data, cfg_status_clear, wake_line;
  logic adv_wake_enable, wake_event_enable, wake_event_status, dyn_powerdown;
  logic smart_powerdown, wake_event_pin_n, wake_event_pin_oe_n;
  int   err_count = 0, checks = 0, cyc = 0, b;
  logic [31:0] mctl [5] = '{32'h20000000, 32'h20000000, 32'h40000000, 32'h40000000, 32'h0};
  logic [5:0]  menv [5] = '{6'h31, 6'h2C, 6'h0E, 6'h3C, 6'h3F};  // gig,pci,sel,div
  always #2 hclk = ~hclk;
  wcfe_regs dut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .main_power_good, .standby_present,
    .host_reset_n, .eeprom_adv_wake_assert_event, .cfg_enable_write, .cfg_enable_data,
    .cfg_status_clear, .link_change_hit(hits[0]), .wake_pattern_hit(hits[1]),
    .exact_match_hit(hits[2]), .hash_group_hit(hits[3]), .broadcast_hit(hits[4]),
    .arp_request_hit(hits[5]), .ipv4_directed_hit(hits[6]), .ipv6_directed_hit(hits[7]),
    .flex_hit(hits[11:8]), .pkt_is_mgmt, .link_is_gig, .pci_is_33mhz, .mac_freq_sel,
    .adv_wake_enable, .wake_event_enable, .wake_event_status, .dyn_powerdown,
    .smart_powerdown, .mac_clk_div, .filter_enables, .wake_event_pin_n, .wake_event_pin_oe_n);
  wcfe_pm_host u_host (.hclk, .wake_event_pin_n, .wake_event_pin_oe_n, .cfg_enable_write,
    .cfg_enable_data, .cfg_status_clear, .wake_line);
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // One single transfer; entered right after an edge, leaves at the data-phase edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'h1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    check(rd, exp);
    check(hresp, 32'h0);
  endtask
  // Filter match strobe lasting one cycle, then time for status to settle
  task automatic pulse(input logic [11:0] v);
    hits <= v;
    tick(1);
    hits <= 12'h0;
    tick(2);
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    tick(16);
    hresetn <= 1'h1;
    tick(6);
    rd_chk(CTL, 32'h8);
    rd_chk(FLT, 32'h0);
    // Each filter: silent while off, wakes once enabled
    for (int i = 0; i < 12; i++) begin
      b = (i < 8) ? i : i + 8;
      pulse(12'h1 << i);
      check(wake_event_status, 32'h0);
      bus(1'h1, FLT, 32'h1 << b);
      tick(1);
      check(filter_enables, 32'h1 << b);
      rd_chk(FLT, 32'h1 << b);
      pulse(12'h1 << i);
      check(wake_event_status, 32'h1);
      bus(1'h1, CTL, 32'h4);
      tick(1);
      check(wake_event_status, 32'h0);
    end
    bus(1'h1, CTL, 32'hF000000F);
    tick(1);
    check({smart_powerdown, dyn_powerdown, wake_event_enable, adv_wake_enable}, 32'hF);
    rd_chk(CTL, 32'hF000000B);
    bus(1'h1, 32'h5804, 32'hFFFFFFFF);
    rd_chk(32'h5804, 32'h0);
    // Automatic MAC clock reduction against link and bus speed
    for (int i = 0; i < 5; i++) begin
      bus(1'h1, CTL, mctl[i]);
      {link_is_gig, pci_is_33mhz, mac_freq_sel} <= menv[i][5:2];
      tick(3);
      check(mac_clk_div, menv[i][1:0]);
    end
    bus(1'h1, FLT, 32'h0);
    bus(1'h1, CTL, 32'hB);
    pulse(12'h2);
    check({wake_event_status, wake_event_pin_oe_n, wake_line}, 32'h4);
    rd_chk(CTL, 32'hF);
    bus(1'h1, CTL, 32'hB);
    tick(1);
    check(wake_event_status, 32'h1);
    u_host.clear_status();
    check(wake_event_status, 32'h0);
    u_host.set_enable(1'h0);
    rd_chk(CTL, 32'h9);
    bus(1'h1, FLT, 32'h8010);
    pkt_is_mgmt <= 1'h1;
    pulse(12'h10);
    check(wake_event_status, 32'h0);
    pkt_is_mgmt <= 1'h0;
    pulse(12'h10);
    check(wake_event_status, 32'h1);
    main_power_good <= 1'h0;
    tick(4);
    main_power_good <= 1'h1;
    tick(4);
    rd_chk(CTL, 32'h8);
    rd_chk(FLT, 32'h0);
    bus(1'h1, FLT, 32'h1);
    eeprom_adv_wake_assert_event <= 1'h0;
    standby_present <= 1'h0;
    host_reset_n <= 1'h0;
    tick(4);
    host_reset_n <= 1'h1;
    tick(8);
    rd_chk(FLT, 32'h0);
    rd_chk(CTL, 32'h0);
    final_report();
  end
endmodule
bind wcfe_regs wcfe_regs_chk #(.NUM_FLEX(NUM_FLEX)) u_chk (.hclk, .hresetn, .hsel, .hwrite,
  .hready, .hreadyout, .haddr, .hwdata, .filter_enables, .htrans, .hsize, .main_power_good,
  .cfg_enable_write, .cfg_enable_data, .link_change_hit, .wake_pattern_hit, .exact_match_hit,
  .hash_group_hit, .broadcast_hit, .arp_request_hit, .ipv4_directed_hit, .ipv6_directed_hit,
  .pkt_is_mgmt, .flex_hit, .adv_wake_enable, .wake_event_enable, .wake_event_status,
  .dyn_powerdown, .smart_powerdown, .wake_event_pin_n, .wake_event_pin_oe_n);
